// >>> voltage_protection_element_tb_top.sv
// Self-checking testbench of the voltage protection element.
`timescale 1ns/1ps
module voltage_protection_element_tb_top
   import vpe_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, block_in, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [15:0] va, vb, vc, rms_a, rms_b, rms_c;
   logic [5:0] outs;
   int failures, checks_done, wn, i;
   // Output indices: pickups then trips, time, inst, ground.
   localparam int PT = 0, PI = 1, PG = 2, TT = 3, TI = 4, TG = 5;

   vpe_top #(.TICK_CYCLES(10), .HOLD_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rms_a(rms_a), .rms_b(rms_b), .rms_c(rms_c), .block_in(block_in),
      .pickup_time(outs[0]), .pickup_inst(outs[1]), .pickup_gnd(outs[2]), .trip_time(outs[3]),
      .trip_inst(outs[4]), .trip_gnd(outs[5]));
   vpe_front i_front (.pclk(pclk), .presetn(presetn), .va(va), .vb(vb), .vc(vc),
      .rms_a(rms_a), .rms_b(rms_b), .rms_c(rms_c));

   // The clock toggles every 50 ns, half of its 100 ns period.
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Expected reset level: fixed band below the knee, percentage above it.
   function automatic logic [16:0] rst_lvl(input logic [15:0] s, input logic ov);
      if (s < 16'h1388)
         return ov ? ((s > 16'h00FA) ? 17'(s - 16'h00FA) : 17'h0_0000) : 17'(s) + 17'h0_00FA;
      return ov ? 17'(32'(s) * 95 / 100) : 17'(32'(s) * 105 / 100);
   endfunction

   task automatic close_out;
      $display("Checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One bus transfer: setup, access held until ready, then release.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wn = 0;
      do
      begin
         @(posedge pclk);
         wn++;
      end
      while (pready !== 1'b1 && wn < 20);
      chk("pready", 32'h1, {31'h0, pready});
      if (pready !== 1'b1)
         close_out();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdv(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd);
   endtask

   task automatic setv(input logic [15:0] v);
      va <= v;
      vb <= v;
      vc <= v;
   endtask

   // Waits, bounded, for one output to reach a level.
   task automatic wt(input string nm, input int k, input logic v, input int lim);
      wn = 0;
      while (wn < lim && outs[k] !== v)
      begin
         @(posedge pclk);
         wn++;
      end
      chk(nm, {31'h0, v}, {31'h0, outs[k]});
      if (outs[k] !== v)
         close_out();
   endtask

   // Pickup edge and reset level of one setting, with the time unit definite or inverse.
   task automatic lvl_case(input logic [15:0] s, input logic ov, input logic inv);
      logic [16:0] r;
      r = rst_lvl(s, ov);
      setv(ov ? 16'h0000 : 16'hFFFF);
      apb(1'b1, ADDR_CTRL, {24'h0, 8'hEC | {6'h00, inv, ov}});
      apb(1'b1, ADDR_INST_PICKUP, {16'h0, s});
      apb(1'b1, ADDR_TIME_PICKUP, {16'h0, s});
      wt("pickup_time", PT, 1'b0, 80);
      setv(ov ? s - 16'h0001 : s + 16'h0001);
      idle(8);
      chk("trip_inst", 32'h0, {31'h0, outs[TI]});
      setv(s);
      wt("trip_inst", TI, 1'b1, 40);
      idle(4);
      chk("pickup_time", {31'h0, ~inv}, {31'h0, outs[PT]});
      if (inv)
      begin
         setv(ov ? s + 16'h0001 : s - 16'h0001);
         wt("pickup_time", PT, 1'b1, 40);
      end
      setv(r[15:0]);
      idle(8);
      chk("trip_inst", 32'h1, {31'h0, outs[TI]});
      setv(ov ? r[15:0] - 16'h0001 : r[15:0] + 16'h0001);
      wt("trip_inst", TI, 1'b0, 40);
      rdv("inst_pickup", ADDR_INST_PICKUP, {16'h0, s});
   endtask

   // Main sequence.
   initial
   begin
      {presetn, psel, penable, pwrite, block_in, paddr, pwdata} = '0;
      {va, vb, vc} = '0;
      failures = 0;
      checks_done = 0;
      seed = 32'h5428_3E92;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdv("ctrl", ADDR_CTRL, 32'h0000_00E1);
      rdv("unmapped", 8'h28, 32'h0000_0000);
      chk("pslverr", 32'h1, {31'h0, err});
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
      setv(16'hFFFF);
      idle(10);
      chk("outputs", 32'h0, {26'h0, outs});
      rdv("status", ADDR_STATUS, 32'h0000_0000);
      lvl_case(16'h1388, 1'b1, 1'b0);
      lvl_case(16'h1387, 1'b0, 1'b0);
      lvl_case(16'h03E8, 1'b1, 1'b1);
      for (i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         lvl_case(16'(32'd1000 + seed % 32'd19000), seed[3], seed[7]);
      end
      // Definite delay of four ticks, interrupted once and then run out.
      setv(16'h0000);
      apb(1'b1, ADDR_CTRL, 32'h0000_00E5);
      apb(1'b1, ADDR_TIME_PICKUP, 32'h0000_2710);
      apb(1'b1, ADDR_TIME_DELAY, 32'h0000_0004);
      wt("pickup_time", PT, 1'b0, 80);
      setv(16'h2AF8);
      idle(25);
      chk("trip_time", 32'h0, {31'h0, outs[TT]});
      setv(16'h0000);
      idle(4);
      setv(16'h2AF8);
      wt("trip_time", TT, 1'b1, 70);
      chk("trip_delay", 32'h1, {31'h0, wn >= 30 && wn <= 55});
      setv(16'h0000);
      wt("trip_time", TT, 1'b0, 10);
      // Masked instant unit picks up and records the event but never trips.
      apb(1'b1, ADDR_CTRL, 32'h0000_00A9);
      apb(1'b1, ADDR_INST_PICKUP, 32'h0000_2710);
      apb(1'b1, ADDR_EVENT, 32'h0000_003F);
      setv(16'h2AF8);
      wt("pickup_inst", PI, 1'b1, 40);
      idle(10);
      chk("trip_inst", 32'h0, {31'h0, outs[TI]});
      rdv("event", ADDR_EVENT, 32'h0000_0002);
      // Block stops a new pickup but not an existing trip.
      setv(16'h0000);
      wt("pickup_inst", PI, 1'b0, 80);
      apb(1'b1, ADDR_CTRL, 32'h0000_00E9);
      block_in <= 1'b1;
      setv(16'h2AF8);
      idle(10);
      chk("pickup_inst", 32'h0, {31'h0, outs[PI]});
      block_in <= 1'b0;
      wt("trip_inst", TI, 1'b1, 40);
      block_in <= 1'b1;
      idle(10);
      chk("trip_inst", 32'h1, {31'h0, outs[TI]});
      setv(16'h0000);
      block_in <= 1'b0;
      wt("pickup_inst", PI, 1'b0, 80);
      // Ground unit on the phase average, overvoltage even in undervoltage mode.
      apb(1'b1, ADDR_GND_PICKUP, 32'h0000_0BB8);
      apb(1'b1, ADDR_CTRL, 32'h0000_00F0);
      idle(6);
      chk("pickup_gnd", 32'h0, {31'h0, outs[PG]});
      va <= 16'h2329;
      idle(6);
      rdv("neutral", ADDR_NEUTRAL, 32'h0000_0BB8);
      wt("pickup_gnd", PG, 1'b1, 40);
      wt("trip_gnd", TG, 1'b1, 40);
      va <= 16'h0000;
      wt("trip_gnd", TG, 1'b0, 40);
      wt("pickup_gnd", PG, 1'b0, 40);
      close_out();
   end
endmodule

// >>> vpe_front.sv
// Model of the measurement front end that feeds the element.
`timescale 1ns/1ps
module vpe_front
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] va,
   input wire logic [15:0] vb,
   input wire logic [15:0] vc,
   output logic [15:0] rms_a,
   output logic [15:0] rms_b,
   output logic [15:0] rms_c
);
   // Readings refresh once a clock, as a converter would, and read zero in reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rms_a <= 16'h0000;
         rms_b <= 16'h0000;
         rms_c <= 16'h0000;
      end
      else
      begin
         rms_a <= va;
         rms_b <= vb;
         rms_c <= vc;
      end
   end
endmodule

// >>> vpe_pkg.sv
// Constants, types and shared arithmetic for the voltage protection element.
package vpe_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TIME_PICKUP = 8'h04;
   localparam logic [7:0] ADDR_TIME_DELAY = 8'h08;
   localparam logic [7:0] ADDR_INST_PICKUP = 8'h0C;
   localparam logic [7:0] ADDR_INST_DELAY = 8'h10;
   localparam logic [7:0] ADDR_GND_PICKUP = 8'h14;
   localparam logic [7:0] ADDR_GND_DELAY = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_EVENT = 8'h20;
   localparam logic [7:0] ADDR_NEUTRAL = 8'h24;

   // Control register fields.
   localparam int CTRL_OV = 0;
   localparam int CTRL_INVERSE = 1;
   localparam int CTRL_EN_LSB = 2;
   localparam int CTRL_UNMASK_LSB = 5;
   localparam logic [7:0] CTRL_RESET = 8'hE1;

   // Unit indices inside the per-unit arrays.
   localparam int U_TIME = 0;
   localparam int U_INST = 1;
   localparam int U_GND = 2;
   localparam int N_UNITS = 3;

   // Field positions in the event register.
   localparam int EV_PICKUP_LSB = 0;
   localparam int EV_TRIP_LSB = 3;

   // Voltage levels in 10 mV steps.
   localparam logic [15:0] KNEE_STD = 16'h1388;
   localparam logic [15:0] BAND_STD = 16'h00FA;
   localparam logic [15:0] KNEE_LOW = 16'h05DC;
   localparam logic [15:0] BAND_LOW = 16'h0050;

   // Reset levels in percent of the setting.
   localparam logic [7:0] PCT_OV_STD = 8'h5F;
   localparam logic [7:0] PCT_UV_STD = 8'h69;
   localparam logic [7:0] PCT_OV_REDH = 8'h62;
   localparam logic [7:0] PCT_UV_REDH = 8'h66;
   localparam logic [7:0] PCT_OV_SPEC = 8'h63;
   localparam logic [7:0] PCT_UV_SPEC = 8'h65;
   localparam logic [24:0] PCT_FULL = 25'h000_0064;

   // Inverse timing: target gain and excess-voltage weighting.
   localparam logic [3:0] INV_GAIN = 4'hA;
   localparam int INV_SHIFT = 6;
   localparam logic [4:0] INV_WEIGHT_MAX = 5'h10;

   // Timing figures and derived cycle counts.
   localparam longint CLK_HZ = 10_000_000;
   localparam longint TICK_MS = 100;
   localparam longint HOLD_MS = 200;
   localparam int TICK_CYC = int'((TICK_MS * CLK_HZ) / 1000);
   localparam int HOLD_CYC = int'((HOLD_MS * CLK_HZ + 999) / 1000);

   // Hysteresis variants.
   typedef enum logic [1:0] {VAR_STD = 2'b00, VAR_LOWR = 2'b01, VAR_REDH = 2'b11, VAR_SPEC = 2'b10} vpe_variant_t;

   // Timing state of a unit, Gray coded along idle, timing, tripped.
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_TIMING = 2'b01, ST_TRIPPED = 2'b11} vpe_state_t;

   // Reset level for a setting, a direction and a variant.
   function automatic logic [16:0] vpe_reset_level(input logic [15:0] s, input logic ov, input vpe_variant_t v);
      logic [7:0] pct;
      logic [24:0] prod;
      logic [16:0] lvl;
      pct = ov ? PCT_OV_STD : PCT_UV_STD;
      if (v == VAR_REDH)
         pct = ov ? PCT_OV_REDH : PCT_UV_REDH;
      else if (v == VAR_SPEC)
         pct = ov ? PCT_OV_SPEC : PCT_UV_SPEC;
      prod = {9'h000, s} * {17'h0_0000, pct};
      lvl = 17'(prod / PCT_FULL);
      if (v == VAR_STD && s < KNEE_STD)
         lvl = ov ? ((s > BAND_STD) ? {1'b0, s - BAND_STD} : 17'h0_0000) : ({1'b0, s} + {1'b0, BAND_STD});
      else if (v == VAR_LOWR && s < KNEE_LOW)
         lvl = ov ? ((s > BAND_LOW) ? {1'b0, s - BAND_LOW} : 17'h0_0000) : ({1'b0, s} + {1'b0, BAND_LOW});
      return lvl;
   endfunction
endpackage

// >>> vpe_top.sv
// Voltage protection element: APB registers, measurement selection, tick and three units.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module vpe_top
   import vpe_pkg::*;
#(
   parameter vpe_variant_t VARIANT = VAR_STD,
   parameter bit HAS_MASK = 1'b1,
   parameter bit HAS_INVERSE = 1'b1,
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int HOLD_CYCLES = HOLD_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] rms_a,
   input wire logic [15:0] rms_b,
   input wire logic [15:0] rms_c,
   input wire logic block_in,
   output logic pickup_time,
   output logic pickup_inst,
   output logic pickup_gnd,
   output logic trip_time,
   output logic trip_inst,
   output logic trip_gnd
);
   logic [7:0] ctrl_reg;
   logic [15:0] pickup_reg [N_UNITS];
   logic [11:0] delay_reg [N_UNITS];
   logic [5:0] event_reg;
   logic [5:0] prev_reg;
   logic [15:0] neutral_derived_voltage_reg;
   logic [15:0] phase_reg;
   logic [22:0] tick_cnt_reg;
   logic tick_reg;
   logic [N_UNITS-1:0] unit_pickup;
   logic [N_UNITS-1:0] unit_trip;
   logic [N_UNITS-1:0] unit_ov;
   logic [N_UNITS-1:0] unit_inv;
   logic [N_UNITS-1:0] unit_unmask;
   logic [15:0] unit_meas [N_UNITS];
   logic [31:0] rd_data;
   logic access;
   logic wr_en;
   logic [17:0] phase_sum;

   // True for every mapped register offset.
   function automatic logic vpe_hit(input logic [7:0] a);
      return a == ADDR_CTRL || a == ADDR_TIME_PICKUP || a == ADDR_TIME_DELAY || a == ADDR_INST_PICKUP
         || a == ADDR_INST_DELAY || a == ADDR_GND_PICKUP || a == ADDR_GND_DELAY || a == ADDR_STATUS
         || a == ADDR_EVENT || a == ADDR_NEUTRAL;
   endfunction

   // Largest or smallest of three phase values.
   function automatic logic [15:0] vpe_pick3(input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] c, input logic want_max);
      logic [15:0] r;
      r = a;
      if (want_max ? (b > r) : (b < r))
         r = b;
      if (want_max ? (c > r) : (c < r))
         r = c;
      return r;
   endfunction

   // The access phase completes on the edge that sees pready high.
   assign access = psel && penable && pready;
   assign wr_en = access && pwrite && vpe_hit(paddr);

   // One wait state: pready rises on the edge after the first access cycle and lasts one cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready)
         begin
            pslverr <= !vpe_hit(paddr);
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
         end
         else
         begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Read multiplexer; unmapped offsets read zero.
   always_comb
   begin
      case (paddr)
         ADDR_CTRL: rd_data = {24'h00_0000, ctrl_reg};
         ADDR_TIME_PICKUP: rd_data = {16'h0000, pickup_reg[U_TIME]};
         ADDR_TIME_DELAY: rd_data = {20'h0_0000, delay_reg[U_TIME]};
         ADDR_INST_PICKUP: rd_data = {16'h0000, pickup_reg[U_INST]};
         ADDR_INST_DELAY: rd_data = {20'h0_0000, delay_reg[U_INST]};
         ADDR_GND_PICKUP: rd_data = {16'h0000, pickup_reg[U_GND]};
         ADDR_GND_DELAY: rd_data = {20'h0_0000, delay_reg[U_GND]};
         ADDR_STATUS: rd_data = {26'h000_0000, unit_trip, unit_pickup};
         ADDR_EVENT: rd_data = {26'h000_0000, event_reg};
         ADDR_NEUTRAL: rd_data = {16'h0000, neutral_derived_voltage_reg};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Settings registers written by software.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= CTRL_RESET;
         for (int i = 0; i < N_UNITS; i++)
         begin
            pickup_reg[i] <= 16'h0000;
            delay_reg[i] <= 12'h000;
         end
      end
      else if (wr_en)
      begin
         case (paddr)
            ADDR_CTRL: ctrl_reg <= pwdata[7:0];
            ADDR_TIME_PICKUP: pickup_reg[U_TIME] <= pwdata[15:0];
            ADDR_TIME_DELAY: delay_reg[U_TIME] <= pwdata[11:0];
            ADDR_INST_PICKUP: pickup_reg[U_INST] <= pwdata[15:0];
            ADDR_INST_DELAY: delay_reg[U_INST] <= pwdata[11:0];
            ADDR_GND_PICKUP: pickup_reg[U_GND] <= pwdata[15:0];
            ADDR_GND_DELAY: delay_reg[U_GND] <= pwdata[11:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Sticky rise events for the recorder; a new rise wins over a clear.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         event_reg <= 6'h00;
         prev_reg <= 6'h00;
      end
      else
      begin
         prev_reg <= {unit_trip, unit_pickup};
         event_reg <= (event_reg & ~((wr_en && paddr == ADDR_EVENT) ? pwdata[5:0] : 6'h00))
            | ({unit_trip, unit_pickup} & ~prev_reg);
      end
   end

   // Measurements: phase value chosen by direction, and the phase average.
   assign phase_sum = {2'b00, rms_a} + {2'b00, rms_b} + {2'b00, rms_c};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_reg <= 16'h0000;
         neutral_derived_voltage_reg <= 16'h0000;
      end
      else
      begin
         phase_reg <= vpe_pick3(rms_a, rms_b, rms_c, ctrl_reg[CTRL_OV]);
         neutral_derived_voltage_reg <= 16'(phase_sum / 18'h0_0003);
      end
   end

   // Periodic tick at the delay-setting resolution.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt_reg <= 23'h00_0000;
         tick_reg <= 1'b0;
      end
      else if (tick_cnt_reg >= 23'(TICK_CYCLES - 1))
      begin
         tick_cnt_reg <= 23'h00_0000;
         tick_reg <= 1'b1;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + 23'h00_0001;
         tick_reg <= 1'b0;
      end
   end

   // Per-unit direction, timing kind, mask and measurement.
   always_comb
   begin
      for (int i = 0; i < N_UNITS; i++)
      begin
         unit_unmask[i] = HAS_MASK ? ctrl_reg[CTRL_UNMASK_LSB + i] : 1'b1;
         unit_ov[i] = ctrl_reg[CTRL_OV];
         unit_inv[i] = 1'b0;
         unit_meas[i] = phase_reg;
      end
      unit_inv[U_TIME] = HAS_INVERSE && ctrl_reg[CTRL_INVERSE];
      unit_ov[U_GND] = 1'b1;
      unit_meas[U_GND] = neutral_derived_voltage_reg;
   end

   // The three units: time, instantaneous and ground.
   for (genvar g = 0; g < N_UNITS; g++)
   begin : g_unit
      vpe_unit #(
         .VARIANT(VARIANT),
         .HOLD_CYCLES(HOLD_CYCLES)
      ) u_unit (
         .pclk(pclk),
         .presetn(presetn),
         .tick(tick_reg),
         .enable(ctrl_reg[CTRL_EN_LSB + g]),
         .ov_mode(unit_ov[g]),
         .inverse(unit_inv[g]),
         .unmask(unit_unmask[g]),
         .block(block_in),
         .meas(unit_meas[g]),
         .setting(pickup_reg[g]),
         .delay(delay_reg[g]),
         .pickup(unit_pickup[g]),
         .trip(unit_trip[g])
      );
   end

   // Unit outputs are flip-flops inside each unit.
   assign pickup_time = unit_pickup[U_TIME];
   assign pickup_inst = unit_pickup[U_INST];
   assign pickup_gnd = unit_pickup[U_GND];
   assign trip_time = unit_trip[U_TIME];
   assign trip_inst = unit_trip[U_INST];
   assign trip_gnd = unit_trip[U_GND];
endmodule

// >>> vpe_top_asserts.sv
// Checker of bus timing and protection outputs of the voltage element.
`timescale 1ns/1ps
module vpe_top_asserts
   import vpe_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] rms_a,
   input wire logic [15:0] rms_b,
   input wire logic [15:0] rms_c,
   input wire logic block_in,
   input wire logic pickup_time,
   input wire logic pickup_inst,
   input wire logic pickup_gnd,
   input wire logic trip_time,
   input wire logic trip_inst,
   input wire logic trip_gnd
);
   logic [31:0] hold_cnt;
   // Counts the cycles for which the time pickup has stood.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hold_cnt <= 32'h0000_0000;
      else if (!pickup_time)
         hold_cnt <= 32'h0000_0000;
      else
         hold_cnt <= hold_cnt + 32'h0000_0001;
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // An access waiting for its answer, then a one-cycle answer.
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   out_reset_a: assert property ($rose(presetn) |-> !trip_time && !trip_inst && !trip_gnd && !pickup_time)
      else $error("Outputs active after reset release");
   apb_answer_a: assert property (s_wait |=> s_answer)
      else $error("Bus answer missing or not one cycle");
   ready_src_a: assert property ($rose(pready) |-> $past(psel) && $past(penable))
      else $error("Ready without an access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("Error flag outside answer");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("Read data outside answer");
   pick_hold_a: assert property ($fell(pickup_time) |-> hold_cnt >= HOLD_CYCLES)
      else $error("Pickup dropped before hold time");
   trip_time_a: assert property ($rose(trip_time) |-> $past(pickup_time))
      else $error("Time trip without pickup");
   trip_inst_a: assert property ($rose(trip_inst) |-> $past(pickup_inst))
      else $error("Instant trip without pickup");
   block_hold_a: assert property (block_in [*4] |-> !$rose(pickup_time) && !$rose(pickup_inst) && !$rose(pickup_gnd))
      else $error("Pickup rose while blocked");
endmodule
bind vpe_top vpe_top_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rms_a(rms_a), .rms_b(rms_b), .rms_c(rms_c), .block_in(block_in),
   .pickup_time(pickup_time), .pickup_inst(pickup_inst), .pickup_gnd(pickup_gnd), .trip_time(trip_time),
   .trip_inst(trip_inst), .trip_gnd(trip_gnd));

// >>> vpe_unit.sv
// One protection unit: level detector with hysteresis, delay timer, pickup stretch and trip mask.
`timescale 1ns/1ps
module vpe_unit
   import vpe_pkg::*;
#(
   parameter vpe_variant_t VARIANT = VAR_STD,
   parameter int HOLD_CYCLES = HOLD_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic enable,
   input wire logic ov_mode,
   input wire logic inverse,
   input wire logic unmask,
   input wire logic block,
   input wire logic [15:0] meas,
   input wire logic [15:0] setting,
   input wire logic [11:0] delay,
   output logic pickup,
   output logic trip
);
   logic level_reg;
   logic [21:0] hold_reg;
   logic [16:0] count_reg;
   vpe_state_t state_reg;
   logic pick_cond;
   logic drop_cond;
   logic [16:0] rst_lvl;
   logic [15:0] diff;
   logic [4:0] weight;
   logic [16:0] target;

   // Pickup and drop-out thresholds; inverse timing uses strict comparisons.
   always_comb
   begin
      rst_lvl = vpe_reset_level(setting, ov_mode, VARIANT);
      if (ov_mode)
         pick_cond = inverse ? (meas > setting) : (meas >= setting);
      else
         pick_cond = inverse ? (meas < setting) : (meas <= setting);
      drop_cond = ov_mode ? ({1'b0, meas} < rst_lvl) : ({1'b0, meas} > rst_lvl);
      diff = (meas > setting) ? meas - setting : setting - meas;
      weight = ((diff >> INV_SHIFT) >= 16'(INV_WEIGHT_MAX)) ? INV_WEIGHT_MAX : 5'(diff >> INV_SHIFT) + 5'h01;
      target = inverse ? {5'h00, delay} * 17'(INV_GAIN) : {5'h00, delay};
   end

   // Raw pickup level; a block clears it unless the unit has already tripped.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level_reg <= 1'b0;
      else if (!enable)
         level_reg <= 1'b0;
      else if (block && state_reg != ST_TRIPPED)
         level_reg <= 1'b0;
      else if (!level_reg && pick_cond)
         level_reg <= 1'b1;
      else if (level_reg && drop_cond)
         level_reg <= 1'b0;
   end

   // Delay timer: steps on each tick while picked up, restarts on any drop-out.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         count_reg <= 17'h0_0000;
      end
      else if (!enable)
      begin
         state_reg <= ST_IDLE;
         count_reg <= 17'h0_0000;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               count_reg <= 17'h0_0000;
               if (level_reg)
                  state_reg <= ST_TIMING;
            end
            ST_TIMING:
            begin
               if (!level_reg)
               begin
                  state_reg <= ST_IDLE;
                  count_reg <= 17'h0_0000;
               end
               else if (count_reg >= target)
                  state_reg <= ST_TRIPPED;
               else if (tick)
                  count_reg <= count_reg + (inverse ? {12'h000, weight} : 17'h0_0001);
            end
            ST_TRIPPED:
            begin
               if (!level_reg)
               begin
                  state_reg <= ST_IDLE;
                  count_reg <= 17'h0_0000;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
               count_reg <= 17'h0_0000;
            end
         endcase
      end
   end

   // Pickup indication stretched to its minimum hold time after each rise.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_reg <= 22'h00_0000;
         pickup <= 1'b0;
      end
      else if (!enable)
      begin
         hold_reg <= 22'h00_0000;
         pickup <= 1'b0;
      end
      else
      begin
         if (level_reg && !pickup)
            hold_reg <= 22'(HOLD_CYCLES - 1);
         else if (hold_reg != 22'h00_0000)
            hold_reg <= hold_reg - 22'h00_0001;
         pickup <= level_reg || (pickup && hold_reg != 22'h00_0000);
      end
   end

   // Trip output; a masked unit still reports pickup but never trips.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trip <= 1'b0;
      else
         trip <= enable && unmask && state_reg == ST_TRIPPED;
   end
endmodule
